// ---- sq_device.sv ----
// Operation
// - command 0x30 returns live comparator states
// - bit 12 is one while reset line low
// - bit 13 shows margin pin or margin bit
// - bits 11:0 hold channel ov/uv pairs
// - command 0x31 returns fixed part code, read only
// - power-up copies stored config within 2 ms
// - host waits for restore before any change
// - software lock blocks all memory writes
// - unlock needs bit 0 clear and key
// - lock pin high blocks memory writes
// - locked writes acknowledged but ignored
// - store copies to memory, naks 120 ms
// - load copies stored config back
// - host edits (not ctrl) and loads only after sequence-down
// - reserved written bits are dropped
// - idle holds line low, start pulses 60 us
// - empty position: 20 us low, then pulse
// - enables follow own delay after falling edge
// - pending supplies stretch line low until up
// - last position ends with 320 us high
// - sequence-down steps the line the same way
// - positions span 1023 shared slots
//
// The APB slave port was decided locally.
module sq_device import sq_pkg::*; #(
  parameter int RESTORE_CYC = RESTORE_CYCLES,
  parameter int STORE_CYC = STORE_CYCLES,
  parameter int FLOAT_CYC = FLOAT_CYCLES,
  parameter logic [15:0] PART_ID = PART_ID_DEFAULT,
  parameter logic [KEY_W-1:0] UNLOCK_KEY = UNLOCK_KEY_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  sq_link_if.dev link,
  input wire logic [NUM_CH-1:0] low_violation_flag,
  input wire logic [NUM_CH-1:0] high_violation_flag,
  input wire logic write_lock_pin,
  input wire logic margin_pin,
  input wire logic reset_line_pin,
  output logic [NUM_CH-1:0] enable_out,
  output logic [POS_W-1:0] seq_position
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta, pin_s2, pin_s3, pin_stable;
  wire [3:0] pins = {link.step_line, reset_line_pin, margin_pin, write_lock_pin};
  wire wp_s = pin_stable[0];
  wire margin_s = pin_stable[1];
  wire rstb_s = pin_stable[2];
  wire line_hi = pin_stable[3];

  // a level counts once the second and third stage agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      pin_stable <= 4'h0;
    end else begin
      pin_meta <= pins;
      pin_s2 <= pin_meta;
      pin_s3 <= pin_s2;
      pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
    end
  end

  // ----------------------------------------------------------------
  // configuration memory and command decode
  // ----------------------------------------------------------------
  logic [15:0] cfg [CFG_WORDS];
  logic [15:0] nvm [CFG_WORDS];
  sq_mem_t mem_state;
  logic [BUSY_W-1:0] busy_cnt;
  logic lock, clear_req;
  logic [2*NUM_CH-1:0] live_pairs;

  wire take = link.req & ~link.ack & ~link.nak;
  wire protect = lock | wp_s;
  wire [3:0] idx = link.cmd[3:0];
  wire is_cfg = link.cmd < CMD_CFG_LIMIT;
  wire on_bit = cfg[IDX_CTRL][CTRL_ON_BIT];
  wire margin_act = margin_s | cfg[IDX_CTRL][CTRL_MARGIN_BIT];
  wire [15:0] status_word = {2'b00, margin_act, ~rstb_s, live_pairs};
  wire key_ok = link.wdata[KEY_LSB +: KEY_W] == UNLOCK_KEY;
  wire [15:0] rd_word = (link.cmd == CMD_STATUS) ? status_word :
                        (link.cmd == CMD_PART_ID) ? PART_ID :
                        (link.cmd == CMD_WLOCK) ? {15'h0000, lock} :
                        is_cfg ? cfg[idx] : 16'h0000;

  // ov in the odd bit, uv in the even bit, channel 6 on top
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_pair
      assign live_pairs[2*gi] = low_violation_flag[gi];
      assign live_pairs[2*gi+1] = high_violation_flag[gi];
    end
  endgenerate

  // nvm is cleared by reset here only because nothing else models it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg[i] <= 16'h0000;
        nvm[i] <= 16'h0000;
      end
      mem_state <= M_BOOT;
      busy_cnt <= BUSY_W'(RESTORE_CYC - 1);
      lock <= 1'b0;
      clear_req <= 1'b0;
      link.ack <= 1'b0;
      link.nak <= 1'b0;
      link.rdata <= 16'h0000;
      link.cfg_ready <= 1'b0;
    end else begin
      link.ack <= 1'b0;
      link.nak <= 1'b0;
      clear_req <= 1'b0;
      if (mem_state != M_READY) begin
        if (busy_cnt == '0) begin
          if (mem_state == M_BOOT) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
              cfg[i] <= nvm[i];
            end
          end
          mem_state <= M_READY;
          link.cfg_ready <= 1'b1;
        end else begin
          busy_cnt <= busy_cnt - 1'b1;
        end
      end
      if (take && mem_state != M_READY) begin
        link.nak <= 1'b1;
      end else if (take) begin
        link.ack <= 1'b1;
        link.rdata <= link.wr ? 16'h0000 : rd_word;
        if (link.wr && is_cfg && !protect) begin
          cfg[idx] <= link.wdata & cfg_mask(idx);
        end
        if (link.wr && link.cmd == CMD_WLOCK) begin
          if (link.wdata[LOCK_BIT]) begin
            lock <= 1'b1;
          end else if (key_ok) begin
            lock <= 1'b0;
          end
        end
        if (link.wr && link.cmd == CMD_STORE && !protect) begin
          for (int i = 0; i < CFG_WORDS; i++) begin
            nvm[i] <= cfg[i];
          end
          mem_state <= M_STORE;
          busy_cnt <= BUSY_W'(STORE_CYC - 1);
        end
        if (link.wr && link.cmd == CMD_LOAD && !protect) begin
          for (int i = 0; i < CFG_WORDS; i++) begin
            cfg[i] <= nvm[i];
          end
        end
        if (link.wr && link.cmd == CMD_CLEAR) begin
          clear_req <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // position step line sequencer
  // ----------------------------------------------------------------
  sq_step_t state, next_state;
  logic [CNT_W-1:0] cnt;
  logic [POS_W-1:0] pos;
  logic dir_up;
  logic [NUM_CH-1:0] sched, ready, next_en;

  // per channel: scheduled here, delay elapsed, supply settled
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      wire [POS_W-1:0] ch_pos = cfg[IDX_POS0 + 4'(gi)][POS_W-1:0];
      wire ton_hit = cnt >= cfg[IDX_TON0 + 4'(gi)];
      assign sched[gi] = (ch_pos == pos) & (pos != '0);
      assign ready[gi] = dir_up ? (enable_out[gi] & ~low_violation_flag[gi]) :
                                  (~enable_out[gi] & low_violation_flag[gi]);
      assign next_en[gi] = clear_req ? 1'b0 :
                           (state == ST_LOW && sched[gi] && !line_hi && ton_hit) ? dir_up :
                           enable_out[gi];
    end
  endgenerate

  wire any_sched = |sched;
  wire all_ready = &(~sched | ready);
  wire hi_done = line_hi & (cnt == CNT_W'(HI_CYCLES - 1));
  wire low_done = ~line_hi & (any_sched ? all_ready : cnt >= CNT_W'(LO_CYCLES - 1));
  wire float_done = line_hi & (cnt == CNT_W'(FLOAT_CYC - 1));
  wire at_last = pos == cfg[IDX_LAST][POS_W-1:0];
  wire restart = next_state != state;
  // counts run only while the sensed line sits at the expected level
  wire level_wrong = (state == ST_LOW) ? line_hi : ~line_hi;

  // next state; same stepping for both directions
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (on_bit && mem_state == M_READY) next_state = ST_HIGH;
      ST_HIGH: if (hi_done) next_state = ST_LOW;
      ST_LOW: if (low_done) next_state = at_last ? ST_FLOAT : ST_HIGH;
      ST_FLOAT: if (float_done) next_state = dir_up ? ST_DONE : ST_IDLE;
      ST_DONE: if (!on_bit) next_state = ST_HIGH;
      default: next_state = ST_IDLE;
    endcase
    if (clear_req) begin
      next_state = ST_IDLE;
    end
  end

  // state, timer, position and direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      pos <= '0;
      dir_up <= 1'b1;
    end else begin
      state <= next_state;
      if (restart || level_wrong) begin
        cnt <= '0;
      end else if (cnt != '1) begin
        cnt <= cnt + 1'b1;
      end
      if (clear_req) begin
        pos <= '0;
      end else if (state == ST_IDLE && next_state == ST_HIGH) begin
        pos <= '0;
        dir_up <= 1'b1;
      end else if (state == ST_DONE && next_state == ST_HIGH) begin
        pos <= '0;
        dir_up <= 1'b0;
      end else if ((state == ST_HIGH && next_state == ST_LOW) || (state == ST_FLOAT && restart)) begin
        pos <= pos + 1'b1;
      end
    end
  end

  // outputs; the line is only ever pulled low, never driven high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.dev_step_oe <= 1'b1;
      link.dev_step_out <= 1'b0;
      link.seq_idle <= 1'b1;
      enable_out <= '0;
      seq_position <= '0;
    end else begin
      link.dev_step_oe <= !(next_state == ST_HIGH || next_state == ST_FLOAT);
      link.dev_step_out <= 1'b0;
      link.seq_idle <= next_state == ST_IDLE;
      enable_out <= next_en;
      seq_position <= pos;
    end
  end

endmodule // sq_device

// ---- sq_host.sv ----
module sq_host import sq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sq_link_if.host link
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic req, wr, busy, done, refused, hold;
  logic [7:0] cmd, nak_cnt;
  logic [15:0] wdata, wdata_reg, rdata_reg;
  logic [2:0] line_sync;
  logic line_s;

  // first access cycle prepares the answer, the second completes it
  wire acc = psel & penable & ~pready;
  wire commit = psel & penable & pready;
  wire mapped = (paddr == ADDR_CMD) | (paddr == ADDR_WDATA) | (paddr == ADDR_RDATA) |
                (paddr == ADDR_STATUS) | (paddr == ADDR_CTRL);
  wire launch = commit & pwrite & (paddr == ADDR_CMD);
  wire [7:0] new_cmd = pwdata[7:0];
  wire new_wr = pwdata[HCMD_WR_BIT];
  wire cfg_cmd = new_cmd < CMD_CFG_LIMIT;
  // config edits other than the control word, and loads, only while the sequence is down
  wire unsafe = ~link.seq_idle & new_wr &
                ((cfg_cmd & (new_cmd[3:0] != IDX_CTRL)) | (new_cmd == CMD_LOAD));
  wire refuse = busy | ~link.cfg_ready | unsafe;
  wire [31:0] status_word = {16'h0000, nak_cnt, 2'b00, link.seq_idle, line_s,
                             link.cfg_ready, refused, done, busy};
  wire [31:0] rd_mux = (paddr == ADDR_CMD) ? {23'h000000, wr, cmd} :
                       (paddr == ADDR_WDATA) ? {16'h0000, wdata_reg} :
                       (paddr == ADDR_RDATA) ? {16'h0000, rdata_reg} :
                       (paddr == ADDR_STATUS) ? status_word :
                       (paddr == ADDR_CTRL) ? {31'h00000000, hold} : 32'h00000000;

  // ----------------------------------------------------------------
  // apb answer, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      if (acc & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // step line level for status; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_sync <= 3'h0;
      line_s <= 1'b0;
    end else begin
      line_sync <= {line_sync[1:0], link.step_line};
      if (line_sync[1] == line_sync[2]) begin
        line_s <= line_sync[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // command launch and device handshake
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 1'b0;
      cmd <= 8'h00;
      wr <= 1'b0;
      wdata <= 16'h0000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      hold <= 1'b0;
      nak_cnt <= 8'h00;
    end else begin
      if (commit & pwrite & (paddr == ADDR_WDATA)) begin
        wdata_reg <= pwdata[15:0];
      end
      if (commit & pwrite & (paddr == ADDR_CTRL)) begin
        hold <= pwdata[HCTRL_HOLD_BIT];
      end
      // the answer is taken even when a refused launch lands on the same edge
      if (req & link.ack) begin
        req <= 1'b0;
        busy <= 1'b0;
        done <= 1'b1;
        rdata_reg <= link.rdata;
      end
      if (launch) begin
        refused <= refuse;
        if (!refuse) begin
          done <= 1'b0;
          req <= 1'b1;
          cmd <= new_cmd;
          wr <= new_wr;
          wdata <= wdata_reg;
          busy <= 1'b1;
        end
      end
      // a command the device naks stays pending and is offered again
      if (req & link.nak & (nak_cnt != 8'hFF)) begin
        nak_cnt <= nak_cnt + 8'h01;
      end
    end
  end

  // software may stretch the step line like a peer with a pending supply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.host_step_oe <= 1'b0;
      link.host_step_out <= 1'b0;
    end else begin
      link.host_step_oe <= hold;
      link.host_step_out <= 1'b0;
    end
  end

  assign link.req = req;
  assign link.cmd = cmd;
  assign link.wr = wr;
  assign link.wdata = wdata;

endmodule // sq_host

// ---- sq_link_if.sv ----
interface sq_link_if;
  logic req;
  logic [7:0] cmd;
  logic wr;
  logic [15:0] wdata;
  logic ack;
  logic nak;
  logic [15:0] rdata;
  logic cfg_ready;
  logic seq_idle;
  logic dev_step_out;
  logic dev_step_oe;
  logic host_step_out;
  logic host_step_oe;
  logic step_line;

  // wired step line: pulled high unless some party drives it low
  assign step_line = ~((dev_step_oe & ~dev_step_out) | (host_step_oe & ~host_step_out));

  modport dev (
    input req, cmd, wr, wdata, step_line,
    output ack, nak, rdata, cfg_ready, seq_idle, dev_step_out, dev_step_oe
  );
  modport host (
    input ack, nak, rdata, cfg_ready, seq_idle, step_line,
    output req, cmd, wr, wdata, host_step_out, host_step_oe
  );
endinterface

// ---- sq_link_sva.sv ----
module sq_link_sva import sq_pkg::*; #(
  parameter int RESTORE_CYC = 8,
  parameter int FLOAT_CYC = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [7:0] cmd,
  input wire logic wr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic nak,
  input wire logic cfg_ready,
  input wire logic dev_step_out,
  input wire logic dev_step_oe,
  input wire logic step_line
);
  localparam int RST_LIM = RESTORE_CYC + 2;
  logic [15:0] hi_cnt;

  // high run of the shared line; saturates so long spans cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 16'h0000;
    end else if (!step_line) begin
      hi_cnt <= 16'h0000;
    end else if (hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end

  // --------------------------------
  // link and step line properties
  // --------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_restore;
    $rose(presetn) |-> ##[1:RST_LIM] cfg_ready;
  endproperty
  property p_ready_held;
    cfg_ready |=> cfg_ready;
  endproperty
  property p_no_early;
    req |-> cfg_ready;
  endproperty
  property p_answer;
    req && !ack && !nak |=> ack || nak;
  endproperty
  property p_pulse;
    ack || nak |-> !(ack && nak) ##1 !(ack || nak);
  endproperty
  property p_req_hold;
    req && !ack |=> req && $stable({cmd, wr, wdata});
  endproperty
  // pulse width seen where the device takes the line low again
  property p_hi_width;
    $rose(dev_step_oe) && $past(step_line) |->
      (hi_cnt >= HI_CYCLES && hi_cnt <= HI_CYCLES + 8) ||
      (hi_cnt >= FLOAT_CYC && hi_cnt <= FLOAT_CYC + 8);
  endproperty
  property p_open_drain;
    dev_step_oe |-> !dev_step_out;
  endproperty

  a_restore: assert property (p_restore) else $error("restore too slow");
  a_ready_held: assert property (p_ready_held) else $error("cfg_ready dropped");
  a_no_early: assert property (p_no_early) else $error("request before restore");
  a_answer: assert property (p_answer) else $error("request not answered");
  a_pulse: assert property (p_pulse) else $error("answer not one pulse");
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  a_hi_width: assert property (p_hi_width) else $error("bad high width");
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  c_nak: cover property (nak);
  c_ack: cover property (ack && !wr);
  c_float: cover property ($rose(dev_step_oe) && hi_cnt < HI_CYCLES);
endmodule // sq_link_sva

// ---- sq_pkg.sv ----
package sq_pkg;

  // ----------------------------------------------------------------
  // clock and step line timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int T_HI_US = 60;
  localparam int T_LO_US = 20;
  localparam int T_FLOAT_US = 320;
  localparam int T_RESTORE_MS = 2;
  localparam int T_STORE_MS = 120;
  localparam int HI_CYCLES = (T_HI_US * CLK_KHZ) / 1000;
  localparam int LO_CYCLES = (T_LO_US * CLK_KHZ) / 1000;
  localparam int FLOAT_CYCLES = (T_FLOAT_US * CLK_KHZ) / 1000;
  localparam int RESTORE_CYCLES = T_RESTORE_MS * CLK_KHZ;
  localparam int STORE_CYCLES = T_STORE_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int CFG_WORDS = 16;
  localparam int POS_W = 10;
  localparam int CNT_W = 16;
  localparam int BUSY_W = 22;
  localparam int KEY_W = 14;
  localparam int KEY_LSB = 2;
  localparam int APB_AW = 8;

  // ----------------------------------------------------------------
  // device command bytes and configuration word layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CFG_LIMIT = 8'h10;
  localparam logic [7:0] CMD_WLOCK = 8'h12;
  localparam logic [7:0] CMD_STORE = 8'h15;
  localparam logic [7:0] CMD_LOAD = 8'h16;
  localparam logic [7:0] CMD_CLEAR = 8'h17;
  localparam logic [7:0] CMD_STATUS = 8'h30;
  localparam logic [7:0] CMD_PART_ID = 8'h31;
  localparam logic [3:0] IDX_POS0 = 4'h0;
  localparam logic [3:0] IDX_TON0 = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'hE;
  localparam logic [3:0] IDX_CTRL = 4'hF;
  localparam logic [15:0] POS_MASK = 16'h03FF;
  localparam logic [15:0] TON_MASK = 16'hFFFF;
  localparam logic [15:0] CTRL_MASK = 16'h0003;
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_MARGIN_BIT = 1;
  localparam int LOCK_BIT = 0;
  localparam int ST_RSTB_BIT = 12;
  localparam int ST_MARGIN_BIT = 13;
  localparam logic [15:0] PART_ID_DEFAULT = 16'h5A01; // arbitrary value
  localparam logic [KEY_W-1:0] UNLOCK_KEY_DEFAULT = 14'h2C5B; // arbitrary value

  // ----------------------------------------------------------------
  // host register map (apb byte addresses) and command/control bits
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] ADDR_CMD = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_WDATA = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_RDATA = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h10;
  localparam int HCMD_WR_BIT = 8;
  localparam int HCTRL_HOLD_BIT = 0;

  // reserved positions of each configuration word read back as zero
  function automatic logic [15:0] cfg_mask(input logic [3:0] idx);
    logic [15:0] m;
    m = 16'h0000;
    if (idx < IDX_POS0 + 4'(NUM_CH)) begin
      m = POS_MASK;
    end else if (idx >= IDX_TON0 && idx < IDX_TON0 + 4'(NUM_CH)) begin
      m = TON_MASK;
    end else if (idx == IDX_LAST) begin
      m = POS_MASK;
    end else if (idx == IDX_CTRL) begin
      m = CTRL_MASK;
    end
    return m;
  endfunction

  typedef enum logic [2:0] {ST_IDLE, ST_HIGH, ST_LOW, ST_FLOAT, ST_DONE} sq_step_t;
  typedef enum logic [1:0] {M_BOOT, M_READY, M_STORE} sq_mem_t;

endpackage

// ---- sq_tb.sv ----
module sq_tb import sq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RCYC = 8;
  localparam int FCYC = 40;
  localparam logic [7:0] POS1 = 8'(IDX_POS0);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0] low_flag = '0;
  logic [NUM_CH-1:0] high_flag = '0;
  logic wlock = 1'b0;
  logic margin = 1'b0;
  logic rst_line = 1'b1;
  logic [NUM_CH-1:0] enable_out;
  logic [POS_W-1:0] seq_position;
  logic [31:0] rd;
  logic slv_err;
  logic [15:0] r16;
  logic [15:0] exp16;
  int n;
  int error_cnt = 0;
  int tests_run = 0;

  always #20 pclk = ~pclk;

  // ------------------
  // the two ends
  // ------------------
  sq_link_if sq_link_if_inst ();
  wire logic step = sq_link_if_inst.step_line;
  sq_host sq_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(sq_link_if_inst));
  sq_device #(.RESTORE_CYC(RCYC), .STORE_CYC(64), .FLOAT_CYC(FCYC)) sq_device_inst (
    .pclk(pclk), .presetn(presetn), .link(sq_link_if_inst), .low_violation_flag(low_flag),
    .high_violation_flag(high_flag), .write_lock_pin(wlock), .margin_pin(margin),
    .reset_line_pin(rst_line), .enable_out(enable_out), .seq_position(seq_position));
  sq_link_sva #(.RESTORE_CYC(RCYC), .FLOAT_CYC(FCYC)) sq_link_sva_inst (.pclk(pclk),
    .presetn(presetn), .req(sq_link_if_inst.req), .cmd(sq_link_if_inst.cmd),
    .wr(sq_link_if_inst.wr), .wdata(sq_link_if_inst.wdata), .ack(sq_link_if_inst.ack),
    .nak(sq_link_if_inst.nak), .cfg_ready(sq_link_if_inst.cfg_ready),
    .dev_step_out(sq_link_if_inst.dev_step_out), .dev_step_oe(sq_link_if_inst.dev_step_oe),
    .step_line(step));

  // ------------------
  // bus and check tasks
  // ------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pulse widths carry a few cycles of line sensing delay
  task automatic rng(input int v, input int lo);
    chk(32'((v >= lo && v <= lo + 8) ? lo : v), 32'(lo));
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one device command; naks are retried by the host until busy clears
  task automatic dcmd(input logic [7:0] c, input logic w, input logic [15:0] d);
    apb(ADDR_WDATA, 1'b1, {16'h0000, d});
    apb(ADDR_CMD, 1'b1, 32'(c) | (32'(w) << HCMD_WR_BIT));
    do begin
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    end while (rd[0] !== 1'b0);
    apb(ADDR_RDATA, 1'b0, 32'h0000_0000);
    r16 = rd[15:0];
  endtask

  task automatic wrd(input logic [7:0] c, input logic [15:0] d);
    dcmd(c, 1'b1, d);
    dcmd(c, 1'b0, 16'h0000);
  endtask

  // waits for the line to reach lvl, then counts cycles it stays there
  task automatic meas(input logic lvl);
    int k;
    k = 0;
    n = 0;
    while (step !== lvl && k < 9000) begin
      @(negedge pclk);
      k++;
    end
    while (step === lvl && n < 9000) begin
      @(negedge pclk);
      n++;
    end
  endtask

  task automatic complete_run();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------
  // scenarios
  // ------------------
  initial begin
    int k;
    logic [7:0] nb;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(ADDR_CMD, 1'b1, 32'(CMD_PART_ID));
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    chk(32'(rd[2]), 32'h1);
    k = 0;
    do begin
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      k++;
    end while (rd[3] !== 1'b1 && k < 20);
    chk(32'(rd[3]), 32'h1);
    apb(8'hFC, 1'b0, 32'h0000_0000);
    chk({rd[30:0], slv_err}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      low_flag <= 6'b100101 ^ {6{i[0]}};
      high_flag <= 6'b011100 ^ {6{i[0]}};
      margin <= i[0];
      rst_line <= !i[0];
      repeat (8) @(posedge pclk);
      dcmd(CMD_STATUS, 1'b0, 16'h0000);
      exp16 = {2'b00, margin, !rst_line, 12'h000};
      for (int j = 0; j < NUM_CH; j++) begin
        exp16[2 * j] = low_flag[j];
        exp16[2 * j + 1] = high_flag[j];
      end
      chk(32'(r16), 32'(exp16));
    end
    margin <= 1'b0;
    dcmd(8'(IDX_CTRL), 1'b1, 16'h0002);
    dcmd(CMD_STATUS, 1'b0, 16'h0000);
    chk(32'(r16[ST_MARGIN_BIT]), 32'h1);
    wrd(CMD_PART_ID, 16'h0000);
    chk(32'(r16), 32'(PART_ID_DEFAULT));
    wrd(POS1, 16'hFFFF);
    chk(32'(r16), 32'(POS_MASK));
    dcmd(CMD_WLOCK, 1'b1, 16'h0001);
    dcmd(CMD_WLOCK, 1'b0, 16'h0000);
    chk(32'(r16), 32'h1);
    wrd(POS1, 16'h0005);
    chk(32'(r16), 32'h03FF);
    dcmd(CMD_WLOCK, 1'b1, {~UNLOCK_KEY_DEFAULT, 2'b00});
    wrd(POS1, 16'h0005);
    chk(32'(r16), 32'h03FF);
    dcmd(CMD_WLOCK, 1'b1, {UNLOCK_KEY_DEFAULT, 2'b00});
    wrd(POS1, 16'h0005);
    chk(32'(r16), 32'h0005);
    @(posedge pclk);
    wlock <= 1'b1;
    repeat (8) @(posedge pclk);
    wrd(POS1, 16'h0007);
    chk(32'(r16), 32'h0005);
    wlock <= 1'b0;
    repeat (8) @(posedge pclk);
    wrd(POS1, 16'h0002);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    nb = rd[15:8];
    dcmd(CMD_STORE, 1'b1, 16'h0000);
    dcmd(CMD_STATUS, 1'b0, 16'h0000);
    apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
    chk(32'(rd[15:8] > nb), 32'h1);
    wrd(POS1, 16'h0009);
    dcmd(CMD_CLEAR, 1'b1, 16'h0000);
    dcmd(CMD_LOAD, 1'b1, 16'h0000);
    dcmd(POS1, 1'b0, 16'h0000);
    chk(32'(r16), 32'h0002);
    dcmd(8'(IDX_TON0), 1'b1, 16'h000A);
    dcmd(8'(IDX_LAST), 1'b1, 16'h0002);
    low_flag <= 6'h01;
    high_flag <= 6'h00;
    repeat (4) @(negedge pclk);
    chk(32'(step), 32'h0);
    // up then down: position 1 empty, channel 1 in position 2
    for (int d = 0; d < 2; d++) begin
      // the line rises before the command task returns, so measure alongside
      fork
        dcmd(8'(IDX_CTRL), 1'b1, 16'(1 - d));
        meas(1'b1);
      join
      rng(n, HI_CYCLES);
      meas(1'b0);
      rng(n, LO_CYCLES);
      meas(1'b1);
      rng(n, HI_CYCLES);
      repeat (6) @(negedge pclk);
      chk(32'(enable_out), 32'(d));
      repeat (24) @(negedge pclk);
      chk(32'(enable_out), 32'(1 - d));
      repeat (600) @(negedge pclk);
      chk(32'(step), 32'h0);
      apb(ADDR_CMD, 1'b1, 32'h0000_0100);
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      chk(32'(rd[2]), 32'h1);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
      low_flag <= 6'(d);
      repeat (60) @(negedge pclk);
      chk({30'h0, sq_link_if_inst.dev_step_oe, step}, 32'h0);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0000);
      meas(1'b1);
      rng(n, FCYC);
      repeat (4) @(negedge pclk);
      chk(32'(seq_position), 32'h3);
    end
    complete_run();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
endmodule // sq_tb
